/* File: i2c_ee_params.svh */
// Constants shared by both ends of the serial memory link.
`ifndef I2C_EE_PARAMS_SVH
`define I2C_EE_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define T_PROG_NS     20000
`define T_QTR_NS      625
`define PROG_CYCLES   ((`T_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QTR_CYCLES    ((`T_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Address and array layout
// ----------------------------------------------------------------------
`define DEV_TYPE      4'hA
`define ADDR_W        11
`define WORD_W        8
`define BLK_W         3
`define PAGE_W        4
`define PAGE_N        16
`define MEM_N         2048
`define LEN_W         12
`define BIT_ACK       4'h8
`define BIT_LAST      4'h7

`endif

/* File: i2c_ee_pkg.sv */
// Types shared by both ends of the serial memory link.
package i2c_ee_pkg;

   // ----------------------------------------------------------------------
   // Device byte-level states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      DST_IDLE,
      DST_DEV,
      DST_WORD,
      DST_WDATA,
      DST_RDATA
   } dev_state_e;

   // ----------------------------------------------------------------------
   // Master states and commands
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      HST_IDLE,
      HST_START,
      HST_SADDR,
      HST_SWORD,
      HST_SDATA,
      HST_RDATA,
      HST_STOP
   } host_state_e;

   typedef enum logic [1:0] {
      OP_WRITE,
      OP_RD_CUR,
      OP_RD_RAND
   } host_op_e;

endpackage

/* File: i2c_ee_link_if.sv */
// Two-wire link joining the bus master and the memory device.
`timescale 1ns/10ps
`default_nettype none

interface i2c_ee_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_b;
   logic dev_sda_o;
   logic dev_sda_oe_b;
   logic sda;

   // Open-drain data line: low whenever any enabled driver pulls it low.
   assign sda = ~((~host_sda_oe_b & ~host_sda_o) | (~dev_sda_oe_b & ~dev_sda_o));

   modport host (output scl, output host_sda_o, output host_sda_oe_b, input sda);
   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_b);
endinterface

`default_nettype wire

/* File: i2c_ee_device.sv */
// Serial memory device: bus slave, page buffer, programming cycle and array.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ee_params.svh"

module i2c_ee_device
   import i2c_ee_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   // Serial link
   i2c_ee_link_if.dev link,
   // Protection and reset pins
   input  wire logic wp_i,
   input  wire logic rst_hi_i,
   input  wire logic rst_lo_b_i,
   // Status
   output logic      busy_o
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam int unsigned PROG_N = `PROG_CYCLES;

   logic                       scl_q;
   logic                       sda_q;
   logic                       scl_p_q;
   logic                       sda_p_q;
   logic                       rise;
   logic                       fall;
   logic                       start_c;
   logic                       stop_c;
   logic                       hold_rst;
   logic [`WORD_W-1:0]         byte_w;
   logic                       dev_hit;
   logic                       take_data;
   logic                       commit;

   dev_state_e                 st_q;
   logic [3:0]                 cnt_q;
   logic [`WORD_W-1:0]         sh_q;
   logic [`WORD_W-1:0]         tx_q;
   logic                       ack_q;
   logic                       drv_q;
   logic [`ADDR_W-1:0]         addr_q;
   logic [`BLK_W-1:0]          blk_q;
   logic [`WORD_W-1:0]         page_q [`PAGE_N];
   logic [`PAGE_N-1:0]         pval_q;
   logic [`ADDR_W-`PAGE_W-1:0] pbase_q;
   logic                       busy_q;
   logic [15:0]                pcnt_q;
   logic [`WORD_W-1:0]         mem [`MEM_N];

   // ----------------------------------------------------------------------
   // Line sampling and bus conditions
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_q   <= link.scl;
         sda_q   <= link.sda;
         scl_p_q <= scl_q;
         sda_p_q <= sda_q;
      end
   end

   assign rise     = scl_q & ~scl_p_q;
   assign fall     = ~scl_q & scl_p_q;
   assign start_c  = scl_q & scl_p_q & sda_p_q & ~sda_q;
   assign stop_c   = scl_q & scl_p_q & ~sda_p_q & sda_q;
   assign hold_rst = rst_hi_i | ~rst_lo_b_i;
   assign byte_w   = {sh_q[`WORD_W-2:0], sda_q};

   // Addressed only when idle from programming and out of reset.
   assign dev_hit = (byte_w[7:4] == `DEV_TYPE) && !busy_q && !hold_rst;

   // Data byte accepted into the page buffer.
   assign take_data = rise && !hold_rst && (st_q == DST_WDATA) && (cnt_q == `BIT_LAST)
                      && !wp_i;

   // ----------------------------------------------------------------------
   // Byte sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q   <= DST_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= '0;
         tx_q   <= '0;
         ack_q  <= 1'b0;
         addr_q <= '0;
         blk_q  <= '0;
      end else if (hold_rst) begin
         st_q  <= DST_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (start_c) begin
         st_q  <= DST_DEV;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (stop_c) begin
         st_q  <= DST_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (rise) begin
         if (cnt_q == `BIT_ACK) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            if (st_q == DST_RDATA && !ack_q) begin
               if (!sda_q) begin
                  tx_q   <= mem[addr_q];
                  addr_q <= addr_q + 1'b1;
               end else begin
                  st_q <= DST_IDLE;
               end
            end
         end else if (st_q == DST_RDATA) begin
            tx_q  <= {tx_q[`WORD_W-2:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
         end else if (st_q != DST_IDLE) begin
            sh_q  <= byte_w;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `BIT_LAST) begin
               case (st_q)
                  DST_DEV: begin
                     if (dev_hit) begin
                        ack_q <= 1'b1;
                        blk_q <= byte_w[3:1];
                        if (byte_w[0]) begin
                           st_q   <= DST_RDATA;
                           tx_q   <= mem[addr_q];
                           addr_q <= addr_q + 1'b1;
                        end else begin
                           st_q <= DST_WORD;
                        end
                     end else begin
                        st_q <= DST_IDLE;
                     end
                  end
                  DST_WORD: begin
                     ack_q  <= 1'b1;
                     addr_q <= {blk_q, byte_w};
                     st_q   <= DST_WDATA;
                  end
                  DST_WDATA: begin
                     if (wp_i) begin
                        st_q <= DST_IDLE;
                     end else begin
                        ack_q <= 1'b1;
                        addr_q[`PAGE_W-1:0] <= addr_q[`PAGE_W-1:0] + 1'b1;
                     end
                  end
                  default: begin
                     st_q <= DST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Data line driver
   // ----------------------------------------------------------------------
   // Apart from release on reset, start or stop, the line only changes after a falling clock.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         drv_q <= 1'b0;
      end else if (hold_rst || start_c || stop_c) begin
         drv_q <= 1'b0;
      end else if (fall) begin
         if (cnt_q == `BIT_ACK) begin
            drv_q <= ack_q;
         end else if (st_q == DST_RDATA) begin
            drv_q <= ~tx_q[`WORD_W-1];
         end else begin
            drv_q <= 1'b0;
         end
      end
   end

   assign link.dev_sda_o    = 1'b0;
   assign link.dev_sda_oe_b = ~drv_q;

   // ----------------------------------------------------------------------
   // Page buffer
   // ----------------------------------------------------------------------
   // Later bytes landing on the same slot overwrite earlier ones.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pval_q  <= '0;
         pbase_q <= '0;
      end else if (commit) begin
         pval_q <= '0;
      end else if (take_data) begin
         page_q[addr_q[`PAGE_W-1:0]] <= byte_w;
         pval_q[addr_q[`PAGE_W-1:0]] <= 1'b1;
         pbase_q <= addr_q[`ADDR_W-1:`PAGE_W];
      end
   end

   // ----------------------------------------------------------------------
   // Programming cycle
   // ----------------------------------------------------------------------
   assign commit = busy_q && (pcnt_q == 16'(PROG_N - 1));

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
         pcnt_q <= 16'h0000;
      end else if (busy_q) begin
         pcnt_q <= pcnt_q + 16'h0001;
         if (commit) begin
            busy_q <= 1'b0;
         end
      end else if (stop_c && (pval_q != '0)) begin
         busy_q <= 1'b1;
         pcnt_q <= 16'h0000;
      end
   end

   assign busy_o = busy_q;

   // ----------------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------------
   // All buffered bytes land in the array on the same edge.
   always_ff @(posedge ref_clk_i) begin
      for (int i = 0; i < `PAGE_N; i++) begin
         if (commit && pval_q[i]) begin
            mem[{pbase_q, `PAGE_W'(i)}] <= page_q[i];
         end
      end
   end

endmodule

`default_nettype wire

/* File: i2c_ee_master.sv */
// Bus master end: drives the clock, start and stop, polls, buffers read data.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ee_params.svh"

module i2c_ee_master
   import i2c_ee_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   // Serial link
   i2c_ee_link_if.host            link,
   // Command
   input  wire logic              cmd_valid_i,
   output logic                   cmd_ready_o,
   input  wire host_op_e          cmd_op_i,
   input  wire logic [`ADDR_W-1:0] cmd_addr_i,
   input  wire logic [`LEN_W-1:0]  cmd_len_i,
   // Write data
   input  wire logic              wr_valid_i,
   input  wire logic [`WORD_W-1:0] wr_data_i,
   output logic                   wr_ready_o,
   // Read data
   output logic                   rd_valid_o,
   output logic [`WORD_W-1:0]     rd_data_o,
   input  wire logic              rd_ready_i,
   // Completion
   output logic                   done_o
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam logic [7:0] QTR_LAST = 8'(`QTR_CYCLES - 1);

   host_state_e          hst_q;
   host_op_e             op_q;
   logic [`ADDR_W-1:0]   addr_q;
   logic [`LEN_W-1:0]    len_q;
   logic                 rdph_q;
   logic                 retry_q;
   logic [1:0]           q_q;
   logic [7:0]           qc_q;
   logic [3:0]           bitn_q;
   logic [`WORD_W-1:0]   tx_q;
   logic [`WORD_W-1:0]   rx_q;
   logic                 samp_q;
   logic                 scl_q;
   logic                 sda_q;
   logic                 done_q;
   logic                 hold;
   logic                 tick;
   logic                 sym_end;
   logic                 rd_st;
   logic                 bitv;
   logic                 scl_n;
   logic                 sda_n;
   logic                 push;
   logic                 pop;
   logic [`WORD_W-1:0]   fm_q [2];
   logic                 fw_q;
   logic                 fr_q;
   logic [1:0]           fc_q;

   // ----------------------------------------------------------------------
   // Bit timing
   // ----------------------------------------------------------------------
   // A stall holds the clock low, which the slave tolerates indefinitely.
   assign rd_st      = (hst_q == HST_RDATA);
   assign wr_ready_o = (hst_q == HST_SDATA) && (bitn_q == 4'h0) && (q_q == 2'd0)
                       && (qc_q == 8'h00);
   assign push       = rd_st && (bitn_q == `BIT_ACK) && (q_q == 2'd0) && (qc_q == 8'h00)
                       && (fc_q != 2'd2);
   assign hold       = (wr_ready_o && !wr_valid_i)
                       || (rd_st && (bitn_q == `BIT_ACK) && (q_q == 2'd0) && (qc_q == 8'h00)
                           && (fc_q == 2'd2));
   assign tick       = (hst_q != HST_IDLE) && !hold && (qc_q == QTR_LAST);
   assign sym_end    = tick && (q_q == 2'd3);

   always_comb begin
      if (bitn_q == `BIT_ACK) begin
         bitv = rd_st ? (len_q == `LEN_W'(1)) : 1'b1;
      end else begin
         bitv = rd_st ? 1'b1 : tx_q[`WORD_W-1];
      end
      case (hst_q)
         HST_IDLE: begin
            scl_n = 1'b1;
            sda_n = 1'b1;
         end
         HST_START: begin
            scl_n = (q_q == 2'd1) || (q_q == 2'd2);
            sda_n = (q_q < 2'd2);
         end
         HST_STOP: begin
            scl_n = (q_q != 2'd0);
            sda_n = (q_q >= 2'd2);
         end
         default: begin
            scl_n = (q_q == 2'd1) || (q_q == 2'd2);
            sda_n = bitv;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_q    <= 2'd0;
         qc_q   <= 8'h00;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         samp_q <= 1'b1;
      end else begin
         scl_q <= scl_n;
         sda_q <= sda_n;
         if (hst_q == HST_IDLE) begin
            q_q  <= 2'd0;
            qc_q <= 8'h00;
         end else if (!hold) begin
            qc_q <= tick ? 8'h00 : qc_q + 8'h01;
            if (tick) begin
               q_q <= q_q + 2'd1;
            end
            if (tick && (q_q == 2'd1)) begin
               samp_q <= link.sda;
            end
         end
      end
   end

   assign link.scl           = scl_q;
   assign link.host_sda_o    = 1'b0;
   assign link.host_sda_oe_b = sda_q;

   // ----------------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------------
   assign cmd_ready_o = (hst_q == HST_IDLE);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hst_q   <= HST_IDLE;
         op_q    <= OP_WRITE;
         addr_q  <= '0;
         len_q   <= '0;
         rdph_q  <= 1'b0;
         retry_q <= 1'b0;
         bitn_q  <= 4'h0;
         tx_q    <= '0;
         rx_q    <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (cmd_valid_i && cmd_ready_o) begin
            hst_q   <= HST_START;
            op_q    <= cmd_op_i;
            addr_q  <= cmd_addr_i;
            len_q   <= cmd_len_i;
            rdph_q  <= (cmd_op_i == OP_RD_CUR);
            retry_q <= 1'b0;
         end
         if (wr_ready_o && wr_valid_i) begin
            tx_q <= wr_data_i;
         end
         if (tick && (q_q == 2'd1) && rd_st && (bitn_q < `BIT_ACK)) begin
            rx_q <= {rx_q[`WORD_W-2:0], link.sda};
         end
         if (sym_end) begin
            case (hst_q)
               HST_START: begin
                  hst_q  <= HST_SADDR;
                  bitn_q <= 4'h0;
                  tx_q   <= {`DEV_TYPE, addr_q[`ADDR_W-1:`WORD_W], rdph_q};
               end
               HST_STOP: begin
                  if (retry_q) begin
                     hst_q   <= HST_START;
                     retry_q <= 1'b0;
                     rdph_q  <= (op_q == OP_RD_CUR);
                  end else begin
                     hst_q  <= HST_IDLE;
                     done_q <= 1'b1;
                  end
               end
               default: begin
                  if (bitn_q != `BIT_ACK) begin
                     bitn_q <= bitn_q + 4'h1;
                     tx_q   <= {tx_q[`WORD_W-2:0], 1'b0};
                  end else begin
                     bitn_q <= 4'h0;
                     case (hst_q)
                        HST_SADDR: begin
                           if (samp_q) begin
                              retry_q <= 1'b1;
                              hst_q   <= HST_STOP;
                           end else if (rdph_q) begin
                              hst_q <= HST_RDATA;
                           end else begin
                              hst_q <= HST_SWORD;
                              tx_q  <= addr_q[`WORD_W-1:0];
                           end
                        end
                        HST_SWORD: begin
                           if (samp_q) begin
                              hst_q <= HST_STOP;
                           end else if (op_q == OP_RD_RAND) begin
                              rdph_q <= 1'b1;
                              hst_q  <= HST_START;
                           end else begin
                              hst_q <= HST_SDATA;
                           end
                        end
                        default: begin
                           len_q <= len_q - `LEN_W'(1);
                           if ((len_q == `LEN_W'(1)) || (!rd_st && samp_q)) begin
                              hst_q <= HST_STOP;
                           end
                        end
                     endcase
                  end
               end
            endcase
         end
      end
   end

   assign done_o = done_q;

   // ----------------------------------------------------------------------
   // Two-entry read buffer
   // ----------------------------------------------------------------------
   assign pop        = (fc_q != 2'd0) && rd_ready_i;
   assign rd_valid_o = (fc_q != 2'd0);
   assign rd_data_o  = fm_q[fr_q];

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fw_q     <= 1'b0;
         fr_q     <= 1'b0;
         fc_q     <= 2'd0;
         fm_q[0]  <= '0;
         fm_q[1]  <= '0;
      end else begin
         if (push) begin
            fm_q[fw_q] <= rx_q;
            fw_q       <= ~fw_q;
         end
         if (pop) begin
            fr_q <= ~fr_q;
         end
         fc_q <= fc_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

`default_nettype wire

/* File: i2c_ee_link_chk.sv */
// Assertions on the two-wire link between bus master and memory device.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ee_params.svh"
module i2c_ee_link_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Link and status
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_b,
   input wire logic busy_o
);
   logic [9:0]  cnt_q;
   logic [15:0] stop_q;
   logic        sda_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Counts programming cycles and remembers recent stop conditions.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q  <= 10'h000;
         stop_q <= 16'h0000;
         sda_q  <= 1'b1;
      end else begin
         cnt_q  <= busy_o ? cnt_q + 10'h001 : 10'h000;
         stop_q <= {stop_q[14:0], scl & sda & ~sda_q};
         sda_q  <= sda;
      end
   end
   property p_busy_len; $fell(busy_o) |-> cnt_q == 10'(`PROG_CYCLES); endproperty
   a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
   property p_busy_max; busy_o |-> cnt_q < 10'(`PROG_CYCLES); endproperty
   a_busy_max: assert property (p_busy_max) else $error("programming too long");
   property p_busy_hold; $rose(busy_o) |=> busy_o [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("programming cut short");
   property p_busy_quiet; busy_o |-> dev_sda_oe_b; endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
   property p_busy_stop; $rose(busy_o) |-> |stop_q; endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("programming without stop");
   property p_scl_hold; scl && $past(scl) |-> $stable(dev_sda_oe_b); endproperty
   a_scl_hold: assert property (p_scl_hold) else $error("data moved with clock high");
   property p_stop_idle; scl && $rose(sda) |-> dev_sda_oe_b [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("driving after stop");
   property p_start_idle; scl && $fell(sda) |-> dev_sda_oe_b [*8]; endproperty
   a_start_idle: assert property (p_start_idle) else $error("driving after start");
   c_prog: cover property ($rose(busy_o));
   c_ack: cover property ($fell(dev_sda_oe_b));
   c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

/* File: tb_i2c_eeprom_access_logic.sv */
// Self-checking bench joining the bus master and the memory device.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ee_params.svh"
module tb_i2c_eeprom_access_logic;
   import i2c_ee_pkg::*;
   typedef struct {logic [10:0] a; int n;} row_s;
   logic clk, rst_b, wp, rst_hi, rst_lo_b, busy, cmd_valid, cmd_ready, done;
   logic wr_valid, wr_ready, rd_valid, rd_ready;
   host_op_e    cmd_op;
   logic [10:0] cmd_addr;
   logic [11:0] cmd_len;
   logic [7:0]  wr_data, rd_data;
   logic [7:0]  wbuf [0:31];
   logic [7:0]  rbuf [0:3];
   logic [7:0]  mdl [0:2047];
   row_s        rows [0:3];
   int          n_mismatch, comparisons, done_cyc, salt, k;
   i2c_ee_link_if link ();
   i2c_ee_master i2c_ee_master_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .link(link.host),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
      .cmd_len_i(cmd_len), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_ready_i(rd_ready), .done_o(done));
   i2c_ee_device i2c_ee_device_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .link(link.dev),
      .wp_i(wp), .rst_hi_i(rst_hi), .rst_lo_b_i(rst_lo_b), .busy_o(busy));
   i2c_ee_link_chk i2c_ee_link_chk_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .scl(link.scl),
      .sda(link.sda), .dev_sda_oe_b(link.dev_sda_oe_b), .busy_o(busy));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Positive hold keeps the high reset pin active, negative the low one.
   task automatic run(input host_op_e op, input logic [10:0] a, input int n, input int stall,
                      input int hold);
      int   i, wi, ri;
      logic tk, dn;
      tk = 0;
      dn = 0;
      wi = 0;
      ri = 0;
      rbuf = '{default: 'x};
      @(posedge clk) #1;
      cmd_valid = 1;
      cmd_op = op;
      cmd_addr = a;
      cmd_len = 12'(n);
      wr_valid = (op == OP_WRITE);
      wr_data = wbuf[0];
      rd_ready = (stall == 0);
      rst_hi = (hold > 0);
      rst_lo_b = (hold >= 0);
      for (i = 0; i < 60000 && !dn; i++) begin
         @(negedge clk);
         if (cmd_valid && cmd_ready) tk = 1;
         if (wr_valid && wr_ready) wi++;
         if (rd_valid && rd_ready) begin
            rbuf[ri] = rd_data;
            ri++;
         end
         if (done) begin
            dn = 1;
            done_cyc = i;
         end
         @(posedge clk) #1;
         if (tk) cmd_valid = 0;
         wr_valid = (op == OP_WRITE) && wi < n;
         wr_data = wbuf[wi];
         rd_ready = (i >= stall);
         rst_hi = (i < hold);
         rst_lo_b = (i >= -hold);
      end
      if (!dn) begin
         n_mismatch++;
         complete_run();
      end
      if (op == OP_WRITE) begin
         check("bytes sent", 8'(wi), 8'(n));
      end else begin
         check("bytes read", 8'(ri), 8'(n));
      end
   endtask
   task automatic wr(input logic [10:0] a, input int n);
      salt = salt + 29;
      for (int i = 0; i < n; i++) begin
         wbuf[i] = 8'(i * 7 + salt);
         if (!wp) mdl[{a[10:4], 4'(a[3:0] + 4'(i))}] = wbuf[i];
      end
      run(OP_WRITE, a, n, 0, 0);
      $display("write test at %h done", a);
   endtask
   task automatic rd(input host_op_e op, input logic [10:0] a, input int n, input int stall,
                     input int hold);
      run(op, a, n, stall, hold);
      for (int i = 0; i < n; i++) check("read byte", mdl[a + 11'(i)], rbuf[i]);
      $display("read test at %h done", a);
   endtask
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_b = 0; wp = 0; rst_hi = 0; rst_lo_b = 1; cmd_valid = 0; cmd_op = OP_WRITE;
      cmd_addr = 11'h000; cmd_len = 12'h001; wr_valid = 0; wr_data = 8'h00; rd_ready = 0;
      n_mismatch = 0; comparisons = 0; salt = 0; done_cyc = 0;
      rows = '{'{11'h123, 1}, '{11'h3FE, 2}, '{11'h7FF, 1}, '{11'h000, 2}};
      repeat (3) @(posedge clk);
      check("reset idle", {link.scl, link.host_sda_oe_b, link.dev_sda_oe_b, cmd_ready,
            wr_ready, rd_valid, done, busy}, 8'hF0);
      #1 rst_b = 1;
      for (k = 0; k < 4; k++) begin
         wr(rows[k].a, rows[k].n);
         check("programming after stop", 8'(busy), 8'h01);
         rd(OP_RD_RAND, rows[k].a, rows[k].n, 0, 0);
      end
      wr(11'h040, 17);
      rd(OP_RD_RAND, 11'h040, 2, 0, 0);
      rd(OP_RD_RAND, 11'h7FF, 3, 3000, 0);
      rd(OP_RD_RAND, 11'h7FF, 1, 0, 0);
      rd(OP_RD_CUR, 11'h000, 1, 0, 0);
      @(posedge clk) #1 wp = 1;
      wr(11'h123, 1);
      check("protected write", 8'(busy), 8'h00);
      @(posedge clk) #1 wp = 0;
      rd(OP_RD_RAND, 11'h123, 1, 0, 0);
      rd(OP_RD_RAND, 11'h123, 1, 0, 3000);
      check("high reset pin", 8'(done_cyc > 3000), 8'h01);
      rd(OP_RD_RAND, 11'h123, 1, 0, -3000);
      check("low reset pin", 8'(done_cyc > 3000), 8'h01);
      complete_run();
   end
endmodule
`default_nettype wire
